// ---- thc_core.sv ----
// Notes on behaviour
// - Mode 1: lift drives pump, lower drives descent.
// - Mode 2 main lift: pump plus main redirect.
// - Mode 2 main lower: descent plus main redirect.
// - Mode 2 aux lift: pump plus aux redirect.
// - Mode 2 aux lower: descent plus aux redirect.
// - Mode 2 valves purely on/off, never modulated.
// - Mode 3: main pair, shared proportional valve.
// - Lift opens valve fully before pump, then reduces.
// - Lowering current rises with potentiometer value.
// - Mode 4: on/off lift, modulated lowering only.
// - Mode 5: local valve only, pump external.
// - Modes 1,5 need module absent; others present.
// - Valve one type: on/off or proportional.
// - Valve two type: on/off or proportional.
// - Module present enables link; absent hides outputs.
// - Belly switch triggers on open or close.
// - Lift/lower calibration captures present pot reading.
// - Brake calibration: min with switch, analog only.
// - Accelerator deadband gives zero speed demand.
// - Two-slope accelerator curve through knee point.
// - Nominal battery select and measured voltage correction.
// - Analog pedal braking linear between calibration points.
`timescale 1ns/1ps
`default_nettype none
module thc_core
  import thc_pkg::*;
#(
  parameter int BATT_W      = 10,
  parameter int PREOPEN_CYC = thc_pkg::THC_PREOPEN_CYC
) (
  input  wire logic               mclk,               // 50 MHz clock.
  input  wire logic               rst_b,              // Asynchronous reset, active low.
  input  wire thc_pkg::thc_req_t  req_pins,           // Lift/lower request pins.
  input  wire logic               belly_switch_in,    // Belly switch pin, high when closed.
  input  wire logic               brake_switch_in,    // Brake pedal switch pin.
  input  wire logic [7:0]         hydraulic_pot_in,   // Potentiometer sample word.
  input  wire logic [7:0]         accel_in,           // Accelerator sample word.
  input  wire logic [2:0]         hyd_mode_in,        // Hydraulics mode 1 to 5.
  input  wire logic               remote_present_in,  // Remote valve module present.
  input  wire logic               valve_one_type_in,  // 0 on/off, 1 proportional.
  input  wire logic               valve_two_type_in,  // 0 on/off, 1 proportional.
  input  wire logic               inversion_switch_level, // 0 open, 1 close.
  input  wire logic               cal_strobe_in,      // Calibration capture pulse.
  input  wire thc_pkg::thc_cal_t  cal_item_in,        // Calibration item.
  input  wire logic               analog_brake_in,    // Analog pedal braking selected.
  input  wire logic [7:0]         release_brake_in,   // Minimum braking strength.
  input  wire logic [7:0]         pedal_brake_in,     // Maximum braking strength.
  input  wire logic [7:0]         accel_deadband,     // Deadband travel.
  input  wire logic [7:0]         accel_knee_travel,  // Knee travel.
  input  wire logic [7:0]         accel_knee_speed,   // Speed at knee.
  input  wire logic [2:0]         batt_nominal_in,    // Nominal battery selection.
  input  wire logic [BATT_W-1:0]  batt_raw_in,        // Measured battery word.
  input  wire logic signed [7:0]  batt_adjust_in,     // Signed correction.
  output thc_pkg::thc_hyd_t       hyd_out,            // Pump, descent, redirect valves.
  output logic [7:0]              prop_valve_return,  // Local proportional valve level.
  output logic [7:0]              remote_valve_one,   // Remote valve one level.
  output logic [7:0]              remote_valve_two,   // Remote valve two level.
  output logic                    remote_link_en,     // Remote module link enable.
  output logic                    mode_fault,         // Mode not allowed here.
  output logic                    quick_inv_out,      // Quick inversion pulse.
  output logic [7:0]              speed_demand,       // Speed demand.
  output logic [7:0]              brake_strength,     // Braking strength, release level unless analog braking with switch.
  output logic [2:0]              batt_nominal_out,   // Applied nominal selection.
  output logic [BATT_W-1:0]       batt_corrected      // Corrected battery word.
);
  import thc_pkg::*;

  localparam int CW = $clog2(PREOPEN_CYC + 1);

  if (BATT_W < 9 || PREOPEN_CYC < 1)
  begin : g_bad_param
    $error("thc_core: BATT_W must be 9 or more and PREOPEN_CYC at least 1.");
  end

  function automatic logic [7:0] thc_map(input logic [7:0] x, input logic [7:0] x0,
                                         input logic [7:0] x1, input logic [7:0] y0,
                                         input logic [7:0] y1);
    logic [7:0]  dy;
    logic [15:0] prod;
    logic [7:0]  q;
    dy   = (y1 >= y0) ? (y1 - y0) : (y0 - y1);
    prod = {8'h00, 8'(x - x0)} * {8'h00, dy};
    q    = THC_ZERO;
    if (x > x0 && x < x1)
    begin
      q = 8'(prod / {8'h00, 8'(x1 - x0)});
    end
    if (x <= x0)
    begin
      thc_map = y0;
    end
    else if (x >= x1)
    begin
      thc_map = y1;
    end
    else
    begin
      thc_map = (y1 >= y0) ? 8'(y0 + q) : 8'(y0 - q);
    end
  endfunction

  logic [THC_SYNC_W-1:0] sync1_reg;
  logic [THC_SYNC_W-1:0] sync2_reg;
  logic                  belly_d_reg;
  thc_req_t              req;
  logic                  belly_s;
  logic                  brake_sw_s;
  logic                  mode_ok;
  logic                  lift_active;
  thc_lift_st_t          lift_st_reg;
  thc_lift_st_t          lift_st_next;
  logic [CW-1:0]         cnt_reg;
  logic [7:0]            lift_lo_reg;
  logic [7:0]            lift_hi_reg;
  logic [7:0]            lower_lo_reg;
  logic [7:0]            lower_hi_reg;
  logic [7:0]            brake_lo_reg;
  logic [7:0]            brake_hi_reg;
  logic [7:0]            lift_level;
  logic [7:0]            lower_level;
  logic [7:0]            prop_level;
  thc_hyd_t              hyd_next;
  logic [7:0]            local_next;
  logic [7:0]            rv1_next;
  logic [7:0]            rv2_next;
  logic [7:0]            speed_next;
  logic signed [BATT_W+1:0] batt_sum;

  // Pins cross in through two flip-flops; only the second stage is read.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_reg   <= '0;
      sync2_reg   <= '0;
      belly_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg   <= {req_pins, belly_switch_in, brake_switch_in};
      sync2_reg   <= sync1_reg;
      belly_d_reg <= sync2_reg[1];
    end
  end

  assign req        = sync2_reg[5:2];
  assign belly_s    = sync2_reg[1];
  assign brake_sw_s = sync2_reg[0];

  always_comb
  begin
    mode_ok = 1'b0;
    if (hyd_mode_in == THC_MODE_SINGLE || hyd_mode_in == THC_MODE_LOCAL_PROP)
    begin
      mode_ok = !remote_present_in;
    end
    else if (hyd_mode_in == THC_MODE_DOUBLE || hyd_mode_in == THC_MODE_PROP ||
             hyd_mode_in == THC_MODE_LOWER_PROP)
    begin
      mode_ok = remote_present_in;
    end
  end

  assign lift_active = mode_ok && req.main_lift &&
                       (hyd_mode_in == THC_MODE_PROP || hyd_mode_in == THC_MODE_LOCAL_PROP);

  // Lift sequence: valve held fully open before the pump is allowed on.
  always_comb
  begin
    lift_st_next = lift_st_reg;
    unique case (lift_st_reg)
      THC_ST_IDLE:    lift_st_next = lift_active ? THC_ST_PREOPEN : THC_ST_IDLE;
      THC_ST_PREOPEN:
      begin
        if (!lift_active)
        begin
          lift_st_next = THC_ST_IDLE;
        end
        else if (cnt_reg == CW'(PREOPEN_CYC - 1))
        begin
          lift_st_next = THC_ST_LIFT;
        end
      end
      THC_ST_LIFT:    lift_st_next = lift_active ? THC_ST_LIFT : THC_ST_IDLE;
      default:        lift_st_next = THC_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lift_st_reg <= THC_ST_IDLE;
      cnt_reg     <= '0;
    end
    else
    begin
      lift_st_reg <= lift_st_next;
      cnt_reg     <= (lift_st_reg == THC_ST_PREOPEN) ? CW'(cnt_reg + 1'b1) : '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lift_lo_reg  <= THC_CAL_LO_RST;
      lift_hi_reg  <= THC_CAL_HI_RST;
      lower_lo_reg <= THC_CAL_LO_RST;
      lower_hi_reg <= THC_CAL_HI_RST;
      brake_lo_reg <= THC_CAL_LO_RST;
      brake_hi_reg <= THC_CAL_HI_RST;
    end
    else if (cal_strobe_in)
    begin
      unique case (cal_item_in)
        THC_CAL_LIFT_LO:  lift_lo_reg  <= hydraulic_pot_in;
        THC_CAL_LIFT_HI:  lift_hi_reg  <= hydraulic_pot_in;
        THC_CAL_LOWER_LO: lower_lo_reg <= hydraulic_pot_in;
        THC_CAL_LOWER_HI: lower_hi_reg <= hydraulic_pot_in;
        THC_CAL_BRAKE_LO:
        begin
          if (analog_brake_in && brake_sw_s)
          begin
            brake_lo_reg <= hydraulic_pot_in;
          end
        end
        THC_CAL_BRAKE_HI:
        begin
          if (analog_brake_in)
          begin
            brake_hi_reg <= hydraulic_pot_in;
          end
        end
        default: ;
      endcase
    end
  end

  assign lift_level  = THC_FULL - thc_map(hydraulic_pot_in, lift_lo_reg, lift_hi_reg,
                                          THC_ZERO, THC_FULL);
  assign lower_level = thc_map(hydraulic_pot_in, lower_lo_reg, lower_hi_reg,
                               THC_ZERO, THC_FULL);

  always_comb
  begin
    prop_level = THC_ZERO;
    if (lift_active && lift_st_reg == THC_ST_PREOPEN)
    begin
      prop_level = THC_FULL;
    end
    else if (lift_active && lift_st_reg == THC_ST_LIFT)
    begin
      prop_level = lift_level;
    end
    else if (req.main_lower && !req.main_lift)
    begin
      prop_level = lower_level;
    end
  end

  always_comb
  begin
    hyd_next   = '0;
    local_next = THC_ZERO;
    rv1_next   = THC_ZERO;
    rv2_next   = THC_ZERO;
    if (mode_ok)
    begin
      unique case (hyd_mode_in)
        THC_MODE_SINGLE:
        begin
          hyd_next.pump    = req.main_lift;
          hyd_next.descent = req.main_lower;
        end
        THC_MODE_DOUBLE:
        begin
          hyd_next.pump          = req.main_lift | req.aux_lift;
          hyd_next.descent       = req.main_lower | req.aux_lower;
          hyd_next.redirect_main = req.main_lift | req.main_lower;
          hyd_next.redirect_aux  = req.aux_lift | req.aux_lower;
          rv1_next               = THC_ZERO;
          rv2_next               = THC_ZERO;
        end
        THC_MODE_PROP:
        begin
          hyd_next.pump    = lift_active && lift_st_reg == THC_ST_LIFT;
          hyd_next.descent = req.main_lower && !req.main_lift;
          rv1_next         = prop_level;
        end
        THC_MODE_LOWER_PROP:
        begin
          hyd_next.pump    = req.main_lift;
          hyd_next.descent = req.main_lower;
          rv1_next         = req.main_lower ? lower_level : THC_ZERO;
          rv2_next         = rv1_next;
        end
        THC_MODE_LOCAL_PROP:
        begin
          local_next = prop_level;
        end
        default: ;
      endcase
    end
    if (valve_one_type_in == THC_VALVE_ONOFF)
    begin
      rv1_next = (rv1_next != THC_ZERO) ? THC_FULL : THC_ZERO;
    end
    if (valve_two_type_in == THC_VALVE_ONOFF)
    begin
      rv2_next = (rv2_next != THC_ZERO) ? THC_FULL : THC_ZERO;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hyd_out           <= '0;
      prop_valve_return <= THC_ZERO;
      remote_valve_one  <= THC_ZERO;
      remote_valve_two  <= THC_ZERO;
      remote_link_en    <= 1'b0;
      mode_fault        <= 1'b0;
    end
    else
    begin
      hyd_out           <= hyd_next;
      prop_valve_return <= local_next;
      remote_valve_one  <= remote_present_in ? rv1_next : THC_ZERO;
      remote_valve_two  <= remote_present_in ? rv2_next : THC_ZERO;
      remote_link_en    <= remote_present_in;
      mode_fault        <= !mode_ok;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      quick_inv_out <= 1'b0;
    end
    else if (inversion_switch_level == THC_INV_ON_OPEN)
    begin
      quick_inv_out <= belly_d_reg && !belly_s;
    end
    else
    begin
      quick_inv_out <= !belly_d_reg && belly_s;
    end
  end

  always_comb
  begin
    if (accel_in <= accel_deadband)
    begin
      speed_next = THC_ZERO;
    end
    else if (accel_in <= accel_knee_travel)
    begin
      speed_next = thc_map(accel_in, accel_deadband, accel_knee_travel,
                           THC_ZERO, accel_knee_speed);
    end
    else
    begin
      speed_next = thc_map(accel_in, accel_knee_travel, THC_FULL,
                           accel_knee_speed, THC_FULL);
    end
  end

  assign batt_sum = $signed({2'b00, batt_raw_in}) + (BATT_W+2)'(batt_adjust_in);

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      speed_demand     <= THC_ZERO;
      brake_strength   <= THC_ZERO;
      batt_nominal_out <= 3'h0;
      batt_corrected   <= '0;
    end
    else
    begin
      speed_demand     <= speed_next;
      brake_strength   <= (analog_brake_in && brake_sw_s) ?
                          thc_map(hydraulic_pot_in, brake_lo_reg, brake_hi_reg,
                                  release_brake_in, pedal_brake_in) :
                          release_brake_in;
      batt_nominal_out <= batt_nominal_in;
      if (batt_sum < 0)
      begin
        batt_corrected <= '0;
      end
      else if (batt_sum[BATT_W])
      begin
        batt_corrected <= '1;
      end
      else
      begin
        batt_corrected <= batt_sum[BATT_W-1:0];
      end
    end
  end

  chk_single_pump_on: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode_ok && hyd_mode_in == THC_MODE_SINGLE && req.main_lift) |=> hyd_out.pump)
    else $error("Mode 1 lift did not drive the pump.");
  chk_double_aux_low: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode_ok && hyd_mode_in == THC_MODE_DOUBLE && req.aux_lower)
    |=> (hyd_out.descent && hyd_out.redirect_aux))
    else $error("Mode 2 aux lower missed descent or redirect.");
  chk_double_no_prop: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode_ok && hyd_mode_in == THC_MODE_DOUBLE)
    |=> (remote_valve_one == THC_ZERO && remote_valve_two == THC_ZERO))
    else $error("Mode 2 drove a proportional valve.");
  chk_preopen_no_pump: assert property (@(posedge mclk) disable iff (!rst_b)
    (lift_active && lift_st_reg == THC_ST_PREOPEN)
    |=> (!hyd_out.pump && (remote_valve_one == THC_FULL || prop_valve_return == THC_FULL)))
    else $error("Pump closed before valve fully open.");
  chk_mode_select_bad: assert property (@(posedge mclk) disable iff (!rst_b)
    !mode_ok |=> (hyd_out == '0 && prop_valve_return == THC_ZERO && mode_fault))
    else $error("Disallowed mode drove outputs.");
  chk_remote_hidden: assert property (@(posedge mclk) disable iff (!rst_b)
    !remote_present_in |=> (remote_valve_one == THC_ZERO && !remote_link_en))
    else $error("Absent remote module still driven.");
  chk_quick_inv_open: assert property (@(posedge mclk) disable iff (!rst_b)
    (inversion_switch_level == THC_INV_ON_OPEN && belly_d_reg && !belly_s) |=> quick_inv_out)
    else $error("Opening belly switch did not trigger.");
  chk_deadband_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    (accel_in <= accel_deadband) |=> (speed_demand == THC_ZERO))
    else $error("Speed demand inside deadband.");
  chk_knee_point: assert property (@(posedge mclk) disable iff (!rst_b)
    (accel_in == accel_knee_travel && accel_knee_travel > accel_deadband)
    |=> (speed_demand == $past(accel_knee_speed)))
    else $error("Knee point speed wrong.");
  chk_cal_lift_lo: assert property (@(posedge mclk) disable iff (!rst_b)
    (cal_strobe_in && cal_item_in == THC_CAL_LIFT_LO)
    |=> (lift_lo_reg == $past(hydraulic_pot_in)))
    else $error("Lift low calibration not captured.");
  chk_idle_all_off: assert property (@(posedge mclk) disable iff (!rst_b)
    (req == '0) |=> (hyd_out == '0 && prop_valve_return == THC_ZERO))
    else $error("Outputs active with no request.");
endmodule // thc_core
`default_nettype wire

// ---- thc_pkg.sv ----
`default_nettype none
package thc_pkg;
  localparam logic [2:0] THC_MODE_SINGLE     = 3'h1;
  localparam logic [2:0] THC_MODE_DOUBLE     = 3'h2;
  localparam logic [2:0] THC_MODE_PROP       = 3'h3;
  localparam logic [2:0] THC_MODE_LOWER_PROP = 3'h4;
  localparam logic [2:0] THC_MODE_LOCAL_PROP = 3'h5;
  localparam int         THC_CLK_NS          = 20;
  localparam int         THC_PREOPEN_NS      = 20000;
  localparam int         THC_PREOPEN_CYC     = (THC_PREOPEN_NS + THC_CLK_NS - 1) / THC_CLK_NS;
  localparam logic [7:0] THC_FULL            = 8'hff;
  localparam logic [7:0] THC_ZERO            = 8'h00;
  localparam logic [7:0] THC_CAL_LO_RST      = 8'h00;
  localparam logic [7:0] THC_CAL_HI_RST      = 8'hff;
  localparam logic       THC_VALVE_ONOFF     = 1'b0;
  localparam logic       THC_INV_ON_OPEN     = 1'b0;
  localparam int         THC_SYNC_W          = 6;

  typedef enum logic [2:0] {
    THC_CAL_LIFT_LO  = 3'h0,
    THC_CAL_LIFT_HI  = 3'h1,
    THC_CAL_LOWER_LO = 3'h2,
    THC_CAL_LOWER_HI = 3'h3,
    THC_CAL_BRAKE_LO = 3'h4,
    THC_CAL_BRAKE_HI = 3'h5
  } thc_cal_t;

  typedef enum logic [2:0] {
    THC_ST_IDLE    = 3'b001,
    THC_ST_PREOPEN = 3'b010,
    THC_ST_LIFT    = 3'b100
  } thc_lift_st_t;

  typedef struct packed {
    logic main_lift;
    logic main_lower;
    logic aux_lift;
    logic aux_lower;
  } thc_req_t;

  typedef struct packed {
    logic pump;
    logic descent;
    logic redirect_main;
    logic redirect_aux;
  } thc_hyd_t;
endpackage
`default_nettype wire

// ---- thc_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module thc_far_model
  import thc_pkg::*;
(
  input  wire logic              mclk,          // Clock shared with the block.
  input  wire logic              rst_b,         // Asynchronous reset, active low.
  input  wire logic [7:0]        pot_set,       // Lever position set by the bench.
  input  wire logic              watch_bypass,  // Bypass ordering is watched.
  input  wire thc_pkg::thc_hyd_t hyd_out,       // Contactor and valve outputs.
  input  wire logic [7:0]        bypass_level,  // Valve between pump and tank.
  output logic [7:0]             pot_word,      // Sampled potentiometer word.
  output logic [15:0]            dry_start_cnt  // Pump starts before the bypass is fully open.
);
  logic       pump_q;
  logic [7:0] bypass_q;

  // The wiper is converted once a clock, as a sampling front end would.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      pot_word <= 8'h00;
    else
      pot_word <= pot_set;
  end

  // A pump started before its bypass is fully open pushes against a shut valve.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pump_q <= 1'b0;
      bypass_q <= 8'h00;
      dry_start_cnt <= 16'h0000;
    end
    else
    begin
      pump_q <= hyd_out.pump;
      bypass_q <= bypass_level;
      if (watch_bypass && hyd_out.pump && !pump_q && bypass_q !== 8'hff)
        dry_start_cnt <= dry_start_cnt + 16'h0001;
    end
  end
endmodule // thc_far_model
`default_nettype wire

// ---- thc_core_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module thc_core_tb_top;
  import thc_pkg::*;
  localparam int PRE = 4;
  logic              mclk, rst_b, belly, brk_sw, t1, t2, inv_lvl, strobe, analog, watch;
  logic              pres, link, fault, qinv;
  thc_req_t          req;
  thc_cal_t          item;
  thc_hyd_t          hyd;
  logic [2:0]        mode, nom, nom_o;
  logic [7:0]        pot_set, pot, accel, rel, ped, db, kt, ks, prv, rv1, rv2, spd, brk;
  logic [9:0]        raw, batt;
  logic signed [7:0] adj;
  logic [15:0]       dry;
  logic [31:0]       v;
  wire logic [7:0]   bypass = (mode == THC_MODE_LOCAL_PROP) ? prv : rv1;
  int                error_cnt, checks_done, cyc, seed, llo, lhi, dlo, dhi;

  thc_far_model far (.mclk(mclk), .rst_b(rst_b), .pot_set(pot_set), .watch_bypass(watch),
    .hyd_out(hyd), .bypass_level(bypass), .pot_word(pot), .dry_start_cnt(dry));
  thc_core #(.BATT_W(10), .PREOPEN_CYC(PRE)) dut (.mclk(mclk), .rst_b(rst_b),
    .req_pins(req), .belly_switch_in(belly), .brake_switch_in(brk_sw),
    .hydraulic_pot_in(pot), .accel_in(accel), .hyd_mode_in(mode), .remote_present_in(pres),
    .valve_one_type_in(t1), .valve_two_type_in(t2), .inversion_switch_level(inv_lvl),
    .cal_strobe_in(strobe), .cal_item_in(item), .analog_brake_in(analog),
    .release_brake_in(rel), .pedal_brake_in(ped), .accel_deadband(db),
    .accel_knee_travel(kt), .accel_knee_speed(ks), .batt_nominal_in(nom),
    .batt_raw_in(raw), .batt_adjust_in(adj), .hyd_out(hyd), .prop_valve_return(prv),
    .remote_valve_one(rv1), .remote_valve_two(rv2), .remote_link_en(link),
    .mode_fault(fault), .quick_inv_out(qinv), .speed_demand(spd), .brake_strength(brk),
    .batt_nominal_out(nom_o), .batt_corrected(batt));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("Counts: %0d checks, %0d mismatches", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input int exp, input string what);
    checks_done++;
    if (exp >= 0 && got !== exp[15:0])
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask

  task automatic chk_hyd(input thc_hyd_t got, input thc_hyd_t exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  function automatic int lin(input int p, input int lo, input int hi);
    return p <= lo ? 0 : p >= hi ? 255 : (p - lo) * 255 / (hi - lo);
  endfunction

  function automatic int typed(input int lvl, input logic t);
    return (t === THC_VALVE_ONOFF && lvl != 0) ? 255 : lvl;
  endfunction

  // Drives one configuration and request set, then compares the settled outputs.
  task automatic run_case(input logic [2:0] m, input logic pr, input logic a, input logic b,
                          input thc_req_t r, input logic [7:0] p);
    int       lvl, low, e1, e2, ep;
    logic     ok;
    thc_hyd_t eh;
    @(posedge mclk);
    mode <= m;
    pres <= pr;
    t1 <= a;
    t2 <= b;
    req <= r;
    pot_set <= p;
    settle(12 + PRE);
    ok = pr ? (m >= 3'h2 && m <= 3'h4) : (m == 3'h1 || m == 3'h5);
    low = r.main_lower ? lin(p, dlo, dhi) : 0;
    lvl = r.main_lift ? 255 - lin(p, llo, lhi) : low;
    eh = (ok && m != 3'h5) ? {m == 3'h2 ? r.main_lift | r.aux_lift : r.main_lift,
      m == 3'h2 ? r.main_lower | r.aux_lower : r.main_lower,
      m == 3'h2 && (r.main_lift | r.main_lower), m == 3'h2 && (r.aux_lift | r.aux_lower)} : '0;
    e1 = !ok ? 0 : m == 3'h3 ? typed(lvl, a) : m == 3'h4 ? typed(low, a) : 0;
    e2 = !ok ? 0 : m == 3'h4 ? typed(low, b) : 0;
    ep = (ok && m == 3'h5) ? lvl : 0;
    chk_hyd(hyd, eh, "pump and valves");
    chk_val(rv1, e1, "valve one");
    chk_val(rv2, e2, "valve two");
    chk_val(prv, ep, "local valve");
    chk_val(fault, !ok, "mode refusal");
    chk_val(link, pr, "link enable");
  endtask

  task automatic capture(input thc_cal_t it, input logic [7:0] p);
    @(posedge mclk);
    pot_set <= p;
    item <= it;
    settle(3);
    @(posedge mclk);
    strobe <= 1'b1;
    @(posedge mclk);
    strobe <= 1'b0;
    settle(3);
  endtask

  task automatic qtest(input logic lvl, input logic to);
    int n;
    @(posedge mclk);
    inv_lvl <= lvl;
    belly <= !to;
    settle(8);
    @(posedge mclk);
    belly <= to;
    n = 0;
    repeat (10)
    begin
      settle(1);
      n += (qinv === 1'b1);
    end
    chk_val(n, (lvl == THC_INV_ON_OPEN) ? !to : to, "inversion pulses");
  endtask

  task automatic btest(input logic an, input logic sw, input logic [7:0] p, input int e);
    @(posedge mclk);
    analog <= an;
    brk_sw <= sw;
    pot_set <= p;
    settle(6);
    chk_val(brk, e, "braking strength");
  endtask

  task automatic stest(input logic [7:0] a, input int e);
    @(posedge mclk);
    accel <= a;
    settle(3);
    chk_val(spd, e, "speed demand");
  endtask

  task automatic vtest(input int r, input int a, input int e);
    @(posedge mclk);
    raw <= r[9:0];
    adj <= a[7:0];
    nom <= r[2:0];
    settle(3);
    chk_val(batt, e, "battery word");
    chk_val(nom_o, r % 8, "battery nominal");
  endtask

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      error_cnt++;
      complete_run;
    end
  end

  initial
  begin
    {belly, brk_sw, t1, t2, inv_lvl, strobe, analog, watch, pres} = '0;
    {req, mode, nom, pot_set, accel, rel, ped, db, kt, ks, raw, adj} = '0;
    item = THC_CAL_LIFT_LO;
    // A legal mode at reset release keeps the first refusal attempt meaningful.
    mode = THC_MODE_SINGLE;
    {error_cnt, checks_done, cyc} = '0;
    seed = 64;
    llo = 0;
    lhi = 255;
    dlo = 0;
    dhi = 255;
    rst_b = 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    settle(1);
    chk_hyd(hyd, '0, "reset outputs");
    repeat (60)
    begin
      v = $random(seed);
      if (v[2:0] >= 3'h3)
        v[9:6] = v[6] ? 4'h8 : v[7] ? 4'h4 : 4'h0;
      run_case(v[2:0], v[20] ? v[2:0] >= 3'h2 && v[2:0] <= 3'h4 : v[3], v[4], v[5],
               v[9:6], v[17:10]);
    end
    $display("Test mode sweep done");
    for (int k = 3; k <= 5; k += 2)
    begin
      run_case(k[2:0], k == 3, 1'b1, 1'b1, 4'h0, 8'h30);
      @(posedge mclk);
      watch <= 1'b1;
      req <= 4'h8;
      settle(5);
      chk_val(bypass, 255, "bypass open first");
      chk_hyd(hyd, '0, "pump waits");
      settle(12);
      chk_val(bypass, 255 - 'h30, "lift level");
      chk_hyd(hyd, {k == 3, 3'b000}, "pump on");
      @(posedge mclk);
      req <= 4'h0;
      settle(6);
      chk_val(bypass, 0, "release");
    end
    watch <= 1'b0;
    chk_val(dry, 0, "pump after bypass");
    $display("Test lift order done");
    capture(THC_CAL_LOWER_LO, 8'h40);
    capture(THC_CAL_LOWER_HI, 8'hc0);
    capture(THC_CAL_LIFT_LO, 8'h20);
    capture(THC_CAL_LIFT_HI, 8'he0);
    {dlo, dhi, llo, lhi} = {32'h40, 32'hc0, 32'h20, 32'he0};
    run_case(THC_MODE_LOWER_PROP, 1'b1, 1'b1, 1'b1, 4'h4, 8'hc0);
    run_case(THC_MODE_LOWER_PROP, 1'b1, 1'b1, 1'b1, 4'h4, 8'h40);
    run_case(THC_MODE_PROP, 1'b1, 1'b1, 1'b1, 4'h8, 8'he0);
    run_case(THC_MODE_PROP, 1'b1, 1'b1, 1'b1, 4'h8, 8'h20);
    $display("Test calibration done");
    for (int k = 0; k < 4; k++)
      qtest(k[1], k[0]);
    $display("Test inversion done");
    @(posedge mclk);
    rel <= 8'h11;
    ped <= 8'hee;
    btest(1'b1, 1'b1, 8'h00, 'h11);
    btest(1'b1, 1'b1, 8'hff, 'hee);
    btest(1'b1, 1'b0, 8'hff, 'h11);
    btest(1'b0, 1'b1, 8'hff, 'h11);
    btest(1'b1, 1'b1, 8'h00, 'h11);
    capture(THC_CAL_BRAKE_LO, 8'h80);
    btest(1'b1, 1'b1, 8'h80, 'h11);
    capture(THC_CAL_BRAKE_HI, 8'h90);
    btest(1'b1, 1'b1, 8'h90, 'hee);
    btest(1'b1, 1'b0, 8'h20, 'h11);
    capture(THC_CAL_BRAKE_LO, 8'h20);
    btest(1'b1, 1'b1, 8'h80, 'h11);
    $display("Test braking done");
    repeat (4)
    begin
      v = $random(seed);
      @(posedge mclk);
      db <= {2'b00, v[5:0]};
      kt <= {2'b00, v[5:0]} + 8'h01 + {1'b0, v[12:6]};
      ks <= v[20:13];
      stest(8'h00, 0);
      stest(db, 0);
      stest(kt, ks);
      stest(8'((db + kt) / 2), ((db + kt) / 2 - db) * ks / (kt - db));
      stest(8'((kt + 255) / 2), ks + ((kt + 255) / 2 - kt) * (255 - ks) / (255 - kt));
      stest(8'hff, 255);
    end
    $display("Test accelerator done");
    vtest(1023, 5, 1023);
    vtest(3, -10, 0);
    vtest(100, 7, 107);
    vtest(500, -128, 372);
    $display("Test battery done");
    complete_run;
  end
endmodule // thc_core_tb_top
`default_nettype wire
